//--- pkg/rcl_pkg.sv
// Function
// - The ready flag rises whenever a new frequency-offset count can be read from the two result registers.
// - Unless inhibited, all channel blocks but signal detection power down 100 ms after signal detect falls.
// - After lock, each failed lock check starts re-checks and out-of-lock comes only once the 2-bit count is spent.
// - A lock regained during the re-checks keeps the lock indication high and zeroes the re-check counter.
// - Each adaptation step of feedback taps 2 to 5 is limited to the 4-bit later-tap limit, for both polarities.
// - The 2-bit scale keeps the tolerance, adds bits 3:1, doubles it, or doubles it and adds bits 3:1.
// - Results update continuously, a written capture trigger forces a capture and hardware clears it when done.
// - The first feedback tap is clamped to the 5-bit first-tap limit during adaptation.
// - Eye-opening interrupts are raised only while the eye-opening interrupt enable is one.
// - One step of each 4-bit eye-opening threshold stands for 8 counts of the measurement.
package rcl_pkg;

   // Register indices; the byte address of a register is four times its index.
   localparam logic [9:0] IDX_EYE_THRESH = 10'h032;
   localparam logic [9:0] IDX_LOCK_POWER = 10'h034;
   localparam logic [9:0] IDX_PPM_TAP1 = 10'h035;
   localparam logic [9:0] IDX_EYE_REF = 10'h036;
   localparam logic [9:0] IDX_PPM_RES_HI = 10'h03B;
   localparam logic [9:0] IDX_PPM_RES_LO = 10'h03C;
   localparam logic [9:0] IDX_PPM_DELTA = 10'h064;

   // Values after reset.
   localparam logic [7:0] RST_EYE_THRESH = 8'h11;
   localparam logic [7:0] RST_LOCK_POWER = 8'h3F;
   localparam logic [7:0] RST_PPM_TAP1 = 8'h1F;
   localparam logic [7:0] RST_EYE_REF = 8'h00;
   localparam logic [7:0] RST_PPM_DELTA = 8'h00;

   // Field positions.
   localparam int unsigned BIT_PPM_RDY = 7;
   localparam int unsigned BIT_PWR_INHIBIT = 6;
   localparam int unsigned BIT_RECHECK_LSB = 4;
   localparam int unsigned BIT_LATER_LSB = 0;
   localparam int unsigned BIT_SCALE_LSB = 6;
   localparam int unsigned BIT_PPM_CAPTURE = 5;
   localparam int unsigned BIT_TAP1_LSB = 0;
   localparam int unsigned BIT_EYE_IRQ_EN = 6;
   localparam int unsigned BIT_HEO_THR_LSB = 4;
   localparam int unsigned BIT_VEO_THR_LSB = 0;

   // Each threshold step is 8 counts, a shift by three.
   localparam int unsigned EYE_THR_SHIFT = 3;

   // Idle power-down delay.
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned PWRDN_TIME_MS = 100;
   localparam int unsigned PWRDN_CYCLES = PWRDN_TIME_MS * (CLK_HZ / 1000);

   // Tolerance scale codes.
   typedef enum logic [1:0] {
      SCALE_X1 = 2'b00,
      SCALE_X1_PLUS = 2'b01,
      SCALE_X2 = 2'b10,
      SCALE_X2_PLUS = 2'b11
   } rcl_scale_e;

   // Frequency-offset counter sample.
   typedef struct packed {
      logic valid;
      logic [15:0] count;
   } rcl_ppm_s;

   // Eye-opening measurement.
   typedef struct packed {
      logic valid;
      logic [7:0] heo;
      logic [7:0] veo;
   } rcl_eye_s;

   // Equalizer feedback tap proposals, all two's complement.
   typedef struct packed {
      logic [5:0] tap1;
      logic [3:0][4:0] step;
   } rcl_dfe_s;

endpackage

//--- rtl/rcl_lock_mon.sv
`timescale 1ns/100ps
`default_nettype none
module rcl_lock_mon
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Lock criteria and check timing.
   input wire logic criteria_ok,
   input wire logic check_stb,
   input wire logic [1:0] recheck_n,
   // Lock indication.
   output logic locked_q,
   output logic [1:0] fail_cnt_q
);

   // Lock is judged only on check strobes so that a single glitch between
   // checks cannot knock the indication down.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         locked_q <= 1'b0;
         fail_cnt_q <= 2'b00;
      end
      else if (check_stb)
      begin
         if (criteria_ok)
         begin
            locked_q <= 1'b1;
            fail_cnt_q <= 2'b00;
         end
         else if (locked_q)
         begin
            if (fail_cnt_q == recheck_n)
            begin
               locked_q <= 1'b0;
               fail_cnt_q <= 2'b00;
            end
            else
            begin
               fail_cnt_q <= fail_cnt_q + 2'b01;
            end
         end
      end
   end

endmodule
`default_nettype wire

//--- rtl/rcl_regs.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module rcl_regs
#(
   parameter int unsigned PWRDN_CYCLES = rcl_pkg::PWRDN_CYCLES
)
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Frequency-offset counter.
   input wire rcl_pkg::rcl_ppm_s ppm_in,
   output logic [9:0] ppm_tol_scaled,
   // Signal detect and idle power-down.
   input wire logic sig_detect,
   output logic chan_power_down,
   // Clock recovery lock.
   input wire logic lock_criteria_ok,
   input wire logic lock_check_stb,
   output logic chan_locked,
   // Feedback equalizer.
   input wire rcl_pkg::rcl_dfe_s dfe_req,
   output rcl_pkg::rcl_dfe_s dfe_out,
   // Eye monitor.
   input wire rcl_pkg::rcl_eye_s eye_in,
   output logic eye_irq
);

   logic [7:0] eye_thresh_q;
   logic [7:0] lock_power_dfe_limit_control_q;
   logic [7:0] ppm_tolerance_and_tap1_limit_q;
   logic [7:0] eye_irq_and_reference_mode_q;
   logic [7:0] ppm_delta_q;
   logic [15:0] ppm_res_q;
   logic ppm_rdy_q;
   logic capture_q;
   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic [9:0] tol_q;
   logic pwrdn_q;
   logic eye_irq_q;
   rcl_pkg::rcl_dfe_s dfe_q;
   logic [$clog2(PWRDN_CYCLES + 1) - 1:0] idle_cnt_q;

   logic [9:0] idx;
   logic aligned;
   logic acc;
   logic wr_en;
   logic [7:0] wbyte;
   logic mapped;
   logic [7:0] rd_byte;
   logic ppm_take;
   logic [15:0] ppm_val;
   logic [1:0] lock_recheck_count;
   logic [3:0] feedback_later_taps_limit;
   logic [4:0] feedback_first_tap_limit;
   rcl_pkg::rcl_scale_e ppm_tolerance_scale;

   // Bus decode; a write lands only at the edge where pready is seen high.
   assign idx = paddr[11:2];
   assign aligned = (paddr[1:0] == 2'b00);
   assign acc = psel && penable;
   assign wr_en = acc && pready_q && pwrite && pstrb[0] && !pslverr_q;
   assign wbyte = pwdata[7:0];

   // Control fields used by the channel logic.
   assign lock_recheck_count = lock_power_dfe_limit_control_q[rcl_pkg::BIT_RECHECK_LSB +: 2];
   assign feedback_later_taps_limit = lock_power_dfe_limit_control_q[rcl_pkg::BIT_LATER_LSB +: 4];
   assign feedback_first_tap_limit = ppm_tolerance_and_tap1_limit_q[rcl_pkg::BIT_TAP1_LSB +: 5];
   assign ppm_tolerance_scale = rcl_pkg::rcl_scale_e'(ppm_tolerance_and_tap1_limit_q[rcl_pkg::BIT_SCALE_LSB +: 2]);

   // Read mux; status bits are merged over the stored bytes.
   always_comb
   begin
      mapped = 1'b1;
      rd_byte = 8'h00;
      unique case (idx)
         rcl_pkg::IDX_EYE_THRESH: rd_byte = eye_thresh_q;
         rcl_pkg::IDX_LOCK_POWER:
         begin
            rd_byte = lock_power_dfe_limit_control_q;
            rd_byte[rcl_pkg::BIT_PPM_RDY] = ppm_rdy_q;
         end
         rcl_pkg::IDX_PPM_TAP1:
         begin
            rd_byte = ppm_tolerance_and_tap1_limit_q;
            rd_byte[rcl_pkg::BIT_PPM_CAPTURE] = capture_q;
         end
         rcl_pkg::IDX_EYE_REF: rd_byte = eye_irq_and_reference_mode_q;
         rcl_pkg::IDX_PPM_RES_HI: rd_byte = ppm_res_q[15:8];
         rcl_pkg::IDX_PPM_RES_LO: rd_byte = ppm_res_q[7:0];
         rcl_pkg::IDX_PPM_DELTA: rd_byte = ppm_delta_q;
         default: mapped = 1'b0;
      endcase
      if (!aligned)
      begin
         mapped = 1'b0;
      end
   end

   // One wait state: the access cycle after setup raises pready for a
   // single cycle, which keeps every bus output straight off a flop.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
      else if (acc && !pready_q)
      begin
         pready_q <= 1'b1;
         prdata_q <= (mapped && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         pslverr_q <= !mapped;
      end
      else
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   // Read-write configuration bytes; the eye-reference byte keeps only bits 7:6.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         eye_thresh_q <= rcl_pkg::RST_EYE_THRESH;
         lock_power_dfe_limit_control_q <= rcl_pkg::RST_LOCK_POWER;
         ppm_tolerance_and_tap1_limit_q <= rcl_pkg::RST_PPM_TAP1;
         eye_irq_and_reference_mode_q <= rcl_pkg::RST_EYE_REF;
         ppm_delta_q <= rcl_pkg::RST_PPM_DELTA;
      end
      else if (wr_en)
      begin
         unique case (idx)
            rcl_pkg::IDX_EYE_THRESH: eye_thresh_q <= wbyte;
            rcl_pkg::IDX_LOCK_POWER: lock_power_dfe_limit_control_q <= wbyte;
            rcl_pkg::IDX_PPM_TAP1: ppm_tolerance_and_tap1_limit_q <= wbyte;
            rcl_pkg::IDX_EYE_REF: eye_irq_and_reference_mode_q <= {wbyte[7:6], 6'b00_0000};
            rcl_pkg::IDX_PPM_DELTA: ppm_delta_q <= wbyte;
            default: ;
         endcase
      end
   end

   // A forced capture takes the counter as it stands; otherwise each new
   // counter sample is taken as it arrives.
   assign ppm_take = capture_q || ppm_in.valid;
   assign ppm_val = ppm_in.count;

   // Capture trigger: software sets it, hardware clears it one cycle later
   // once the capture is done. A new write in that cycle wins.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         capture_q <= 1'b0;
      end
      else if (wr_en && idx == rcl_pkg::IDX_PPM_TAP1 && wbyte[rcl_pkg::BIT_PPM_CAPTURE])
      begin
         capture_q <= 1'b1;
      end
      else if (capture_q)
      begin
         capture_q <= 1'b0;
      end
   end

   // Result registers.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ppm_res_q <= 16'h0000;
      end
      else if (ppm_take)
      begin
         ppm_res_q <= ppm_val;
      end
   end

   // Ready flag: writing zero clears it, a new result in the same cycle wins.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ppm_rdy_q <= 1'b0;
      end
      else if (ppm_take)
      begin
         ppm_rdy_q <= 1'b1;
      end
      else if (wr_en && idx == rcl_pkg::IDX_LOCK_POWER && !wbyte[rcl_pkg::BIT_PPM_RDY])
      begin
         ppm_rdy_q <= 1'b0;
      end
   end

   // Scaled tolerance is kept at ten bits so that doubling never wraps.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tol_q <= 10'h000;
      end
      else
      begin
         unique case (ppm_tolerance_scale)
            rcl_pkg::SCALE_X1: tol_q <= {2'b00, ppm_delta_q};
            rcl_pkg::SCALE_X1_PLUS: tol_q <= {2'b00, ppm_delta_q} + {7'h00, ppm_delta_q[3:1]};
            rcl_pkg::SCALE_X2: tol_q <= {1'b0, ppm_delta_q, 1'b0};
            rcl_pkg::SCALE_X2_PLUS: tol_q <= {1'b0, ppm_delta_q, 1'b0} + {7'h00, ppm_delta_q[3:1]};
         endcase
      end
   end

   // Idle timer: runs while signal detect is low and saturates at the
   // delay. Signal detect itself stays powered, so it can end the idle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         idle_cnt_q <= '0;
         pwrdn_q <= 1'b0;
      end
      else if (sig_detect || lock_power_dfe_limit_control_q[rcl_pkg::BIT_PWR_INHIBIT])
      begin
         idle_cnt_q <= '0;
         pwrdn_q <= 1'b0;
      end
      else if (idle_cnt_q == ($bits(idle_cnt_q))'(PWRDN_CYCLES - 1))
      begin
         pwrdn_q <= 1'b1;
      end
      else
      begin
         idle_cnt_q <= idle_cnt_q + 1'b1;
      end
   end

   // Lock indication and its re-check counter.
   rcl_lock_mon rcl_lock_mon_inst
   (
      .pclk(pclk),
      .presetn(presetn),
      .criteria_ok(lock_criteria_ok),
      .check_stb(lock_check_stb),
      .recheck_n(lock_recheck_count),
      .locked_q(chan_locked),
      .fail_cnt_q()
   );

   // First tap clamped to plus or minus its limit.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dfe_q.tap1 <= 6'h00;
      end
      else if ($signed(dfe_req.tap1) > $signed({1'b0, feedback_first_tap_limit}))
      begin
         dfe_q.tap1 <= {1'b0, feedback_first_tap_limit};
      end
      else if ($signed(dfe_req.tap1) < -$signed({1'b0, feedback_first_tap_limit}))
      begin
         dfe_q.tap1 <= 6'(-$signed({1'b0, feedback_first_tap_limit}));
      end
      else
      begin
         dfe_q.tap1 <= dfe_req.tap1;
      end
   end

   // Later taps: each step is held to the same limit in both directions.
   for (genvar t = 0; t < 4; t++)
   begin : g_later
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            dfe_q.step[t] <= 5'h00;
         end
         else if ($signed(dfe_req.step[t]) > $signed({1'b0, feedback_later_taps_limit}))
         begin
            dfe_q.step[t] <= {1'b0, feedback_later_taps_limit};
         end
         else if ($signed(dfe_req.step[t]) < -$signed({1'b0, feedback_later_taps_limit}))
         begin
            dfe_q.step[t] <= 5'(-$signed({1'b0, feedback_later_taps_limit}));
         end
         else
         begin
            dfe_q.step[t] <= dfe_req.step[t];
         end
      end
   end

   // Eye interrupt: raised when a measurement falls below its threshold,
   // dropped by a good measurement or by clearing the enable.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         eye_irq_q <= 1'b0;
      end
      else if (!eye_irq_and_reference_mode_q[rcl_pkg::BIT_EYE_IRQ_EN])
      begin
         eye_irq_q <= 1'b0;
      end
      else if (eye_in.valid)
      begin
         eye_irq_q <= (eye_in.heo < (8'(eye_thresh_q[rcl_pkg::BIT_HEO_THR_LSB +: 4]) << rcl_pkg::EYE_THR_SHIFT))
            || (eye_in.veo < (8'(eye_thresh_q[rcl_pkg::BIT_VEO_THR_LSB +: 4]) << rcl_pkg::EYE_THR_SHIFT));
      end
   end

   // Outputs straight from flops.
   assign pready = pready_q;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;
   assign ppm_tol_scaled = tol_q;
   assign chan_power_down = pwrdn_q;
   assign dfe_out = dfe_q;
   assign eye_irq = eye_irq_q;

endmodule
`default_nettype wire

//--- dv/rcl_regs_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module rcl_regs_checker
#(
   parameter int unsigned PWRDN_CYCLES = rcl_pkg::PWRDN_CYCLES
)
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Channel status.
   input wire logic sig_detect,
   input wire logic chan_power_down,
   input wire logic lock_criteria_ok,
   input wire logic lock_check_stb,
   input wire logic chan_locked,
   // Equalizer and eye monitor.
   input wire rcl_pkg::rcl_dfe_s dfe_out,
   input wire rcl_pkg::rcl_eye_s eye_in,
   input wire logic eye_irq
);
   // One clock domain, so clocking and reset are named once.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Edges seen with signal detect low; it saturates so it never wraps.
   logic [31:0] low_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         low_q <= 32'h0;
      else if (sig_detect)
         low_q <= 32'h0;
      else if (low_q != 32'hFFFFFFFF)
         low_q <= low_q + 32'h1;
   end

   AST_PD_DROPS: assert property (sig_detect |=> !chan_power_down)
      else $error("power-down with signal present");
   AST_PD_WAIT: assert property ($rose(chan_power_down) |-> low_q >= PWRDN_CYCLES - 1)
      else $error("power-down too early");
   AST_LOCK_KEEP: assert property (lock_check_stb && lock_criteria_ok |=> chan_locked)
      else $error("lock lost on a passing check");
   AST_LOCK_DROP: assert property ($fell(chan_locked) |-> $past(lock_check_stb && !lock_criteria_ok))
      else $error("lock dropped without a failing check");
   AST_LOCK_STILL: assert property (!$past(lock_check_stb) |-> $stable(chan_locked))
      else $error("lock changed between checks");
   AST_TAP1_RANGE: assert property (dfe_out.tap1 != 6'h20)
      else $error("first tap beyond any limit");
   AST_STEP_RANGE: assert property (dfe_out.step[0] != 5'h10 && dfe_out.step[1] != 5'h10 &&
      dfe_out.step[2] != 5'h10 && dfe_out.step[3] != 5'h10)
      else $error("later tap step beyond any limit");
   AST_EYE_CAUSE: assert property ($rose(eye_irq) |-> $past(eye_in.valid))
      else $error("eye interrupt without a measurement");
   AST_EYE_THR: assert property ($rose(eye_irq) |-> $past(eye_in.heo < 8'h78 || eye_in.veo < 8'h78))
      else $error("eye interrupt above every threshold");
endmodule
bind rcl_regs rcl_regs_checker #(.PWRDN_CYCLES(PWRDN_CYCLES)) rcl_regs_checker_inst
(
   .pclk(pclk), .presetn(presetn), .sig_detect(sig_detect), .chan_power_down(chan_power_down),
   .lock_criteria_ok(lock_criteria_ok), .lock_check_stb(lock_check_stb), .chan_locked(chan_locked),
   .dfe_out(dfe_out), .eye_in(eye_in), .eye_irq(eye_irq)
);
`default_nettype wire

//--- dv/rcl_host.sv
`timescale 1ns/100ps
`default_nettype none
module rcl_host
(
   // Clock.
   input wire logic pclk,
   // Request.
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   // Answer.
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr
);
   // Idle bus at time zero.
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hF;
   end

   // One transfer; held until pready is seen at an edge, with no cycle count assumed.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- dv/rcl_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module rcl_regs_bench;
   localparam int PW = 20;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, ex;
   logic sig_detect, chan_power_down, lock_criteria_ok, lock_check_stb, chan_locked, eye_irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, rnd;
   logic [3:0] pstrb;
   logic [8:0] lim;
   logic [9:0] ppm_tol_scaled;
   rcl_pkg::rcl_ppm_s ppm_in;
   rcl_pkg::rcl_dfe_s dfe_req, dfe_out;
   rcl_pkg::rcl_eye_s eye_in;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [11:0] ra [5] = '{12'h0C8, 12'h0D0, 12'h0D4, 12'h0D8, 12'h190};
   logic [7:0] rv [5] = '{8'h11, 8'h3F, 8'h1F, 8'h00, 8'h00};

   rcl_regs #(.PWRDN_CYCLES(PW)) rcl_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .ppm_in(ppm_in), .ppm_tol_scaled(ppm_tol_scaled),
      .sig_detect(sig_detect), .chan_power_down(chan_power_down), .lock_criteria_ok(lock_criteria_ok),
      .lock_check_stb(lock_check_stb), .chan_locked(chan_locked), .dfe_req(dfe_req), .dfe_out(dfe_out),
      .eye_in(eye_in), .eye_irq(eye_irq));
   rcl_host rcl_host_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr));

   // Clock of 40 ns.
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // A hang ends the run as a failure.
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         bad_count++;
         report_and_stop();
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   // Scaled tolerance: optional doubling plus optional bits 3:1.
   function automatic logic [9:0] tol(input logic [1:0] s, input logic [7:0] d);
      return (s[1] ? {1'b0, d, 1'b0} : {2'h0, d}) + (s[0] ? {7'h0, d[3:1]} : 10'h0);
   endfunction

   // Symmetric clamp of a signed value.
   function automatic logic [5:0] clp(input logic [5:0] v, input logic [4:0] l);
      if ($signed(v) > $signed({1'b0, l}))
         return {1'b0, l};
      if ($signed(v) < -$signed({1'b0, l}))
         return -{1'b0, l};
      return v;
   endfunction

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      rcl_host_inst.xfer(1'b1, a, d, rd, er);
   endtask

   // Read a register and compare the masked byte.
   task automatic rdc(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
      rcl_host_inst.xfer(1'b0, a, 8'h00, rd, er);
      chk($sformatf("reg %h", a), {24'h0, e}, rd & {24'h0, m});
   endtask

   task automatic lchk(input logic ok);
      @(posedge pclk);
      lock_criteria_ok <= ok;
      lock_check_stb <= 1'b1;
      @(posedge pclk);
      lock_check_stb <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      presetn = 1'b0;
      sig_detect = 1'b1;
      lock_criteria_ok = 1'b0;
      lock_check_stb = 1'b0;
      ppm_in = '0;
      dfe_req = '0;
      eye_in = '0;
      rnd = 32'h5384;
      repeat (6)
         @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, then an unmapped word that must be refused.
      for (int i = 0; i < 5; i++)
         rdc(ra[i], 8'hFF, rv[i]);
      rcl_host_inst.xfer(1'b0, 12'h004, 8'h00, rd, er);
      chk("slverr", 32'h1, {31'h0, er});
      // A sample sets the flag; software clears it; a forced capture sets it again.
      rnd = xs(rnd);
      ppm_in <= {1'b1, rnd[15:0]};
      @(posedge pclk);
      ppm_in.valid <= 1'b0;
      rdc(12'h0D0, 8'h80, 8'h80);
      rdc(12'h0EC, 8'hFF, rnd[15:8]);
      rdc(12'h0F0, 8'hFF, rnd[7:0]);
      wr(12'h0D0, 8'h3F);
      rdc(12'h0D0, 8'h80, 8'h00);
      ppm_in.count <= rnd[31:16];
      wr(12'h0D4, 8'h3F);
      rdc(12'h0D4, 8'hFF, 8'h1F);
      rdc(12'h0D0, 8'h80, 8'h80);
      rdc(12'h0EC, 8'hFF, rnd[31:24]);
      // Every scale code against a random tolerance.
      for (int s = 0; s < 4; s++)
      begin
         rnd = xs(rnd);
         wr(12'h190, rnd[7:0]);
         wr(12'h0D4, {s[1:0], 6'h1F});
         repeat (2)
            @(posedge pclk);
         chk("tol", {22'h0, tol(s[1:0], rnd[7:0])}, {22'h0, ppm_tol_scaled});
      end
      // Random limits and proposals come out clamped.
      for (int k = 0; k < 10; k++)
      begin
         rnd = xs(rnd);
         lim = rnd[8:0];
         wr(12'h0D0, {4'h3, lim[3:0]});
         wr(12'h0D4, {3'h0, lim[8:4]});
         rnd = xs(rnd);
         dfe_req <= rnd[25:0];
         repeat (2)
            @(posedge pclk);
         chk("tap1", {26'h0, clp(dfe_req.tap1, lim[8:4])}, {26'h0, dfe_out.tap1});
         for (int i = 0; i < 4; i++)
            chk("step", {26'h0, clp({dfe_req.step[i][4], dfe_req.step[i]}, {1'b0, lim[3:0]})},
               {26'h0, dfe_out.step[i][4], dfe_out.step[i]});
      end
      // Each re-check count: N failures hold the lock and one more drops it.
      for (int n = 0; n < 4; n++)
      begin
         wr(12'h0D0, {2'h0, n[1:0], 4'hF});
         lchk(1'b1);
         repeat (n)
            lchk(1'b0);
         chk("held", 32'h1, {31'h0, chan_locked});
         lchk(1'b0);
         chk("drop", 32'h0, {31'h0, chan_locked});
      end
      // A pass in mid-sequence restarts the count.
      lchk(1'b1);
      lchk(1'b0);
      lchk(1'b0);
      lchk(1'b1);
      repeat (3)
         lchk(1'b0);
      chk("regain", 32'h1, {31'h0, chan_locked});
      // Idle power-down timing, then the inhibit holds power on.
      sig_detect <= 1'b0;
      repeat (PW - 2)
         @(posedge pclk);
      chk("pd early", 32'h0, {31'h0, chan_power_down});
      repeat (4)
         @(posedge pclk);
      chk("pd", 32'h1, {31'h0, chan_power_down});
      sig_detect <= 1'b1;
      wr(12'h0D0, 8'h7F);
      chk("pd off", 32'h0, {31'h0, chan_power_down});
      sig_detect <= 1'b0;
      repeat (PW + 5)
         @(posedge pclk);
      chk("inhibit", 32'h0, {31'h0, chan_power_down});
      // Thresholds step by 8 counts; the enable gates the interrupt.
      for (int k = 0; k < 16; k++)
      begin
         rnd = xs(rnd);
         wr(12'h0C8, rnd[7:0]);
         wr(12'h0D8, {1'b0, rnd[8], 6'h00});
         eye_in <= {1'b1, 1'b0, rnd[22:16], 1'b0, rnd[30:24]};
         @(posedge pclk);
         eye_in.valid <= 1'b0;
         @(posedge pclk);
         ex = rnd[8] && (eye_in.heo < {rnd[7:4], 3'h0} || eye_in.veo < {rnd[3:0], 3'h0});
         chk("irq", {31'h0, ex}, {31'h0, eye_irq});
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
